// [rtl/bpbc_pkg.sv]
// package of constants for the board power and boot controller
`default_nettype none
package bpbc_pkg;
    // clock rate and sequencing tick
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    // register addresses (byte wide bank over the i2c target)
    localparam logic [7:0] ADDR_BOARD_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_BACKLIGHT_DUTY = 8'h01;
    localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h07;
    // board_control field positions
    localparam int CTL_ROUTE_LSB = 0;
    localparam int CTL_CAM_LSB = 2;
    localparam int CTL_CARRIER_RST = 4;
    // reset values
    localparam logic [7:0] BOARD_CONTROL_RST = 8'h00;
    localparam logic [7:0] BACKLIGHT_DUTY_RST = 8'h00;
    // camera routing encodings
    localparam logic [1:0] ROUTE_ONE_10BIT = 2'h0;
    localparam logic [1:0] ROUTE_TWO_8BIT = 2'h1;
    localparam logic [1:0] ROUTE_ONE_16BIT = 2'h2;
    localparam logic [1:0] ROUTE_INVALID = 2'h3;
    // number of rails and ticks between carrier power and cpu release
    localparam int NUM_RAILS = 6;
    localparam int RELEASE_TICKS = 1;
endpackage
`default_nettype wire

// [rtl/bpbc_sync.sv]
// three stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bpbc_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // pin in, filtered level out
    input wire logic pin,
    output logic level
);
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;

    // shift chain; level follows only when stages two and three agree
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            s1 <= RESET_VALUE;
            s2 <= RESET_VALUE;
            s3 <= RESET_VALUE;
            level <= RESET_VALUE;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end
endmodule
`default_nettype wire

// [rtl/bpbc_board_power_boot_controller.sv]
// board power sequencer, boot strap driver, led remap and register bank
`timescale 1ns/1ps
`default_nettype none

module bpbc_board_power_boot_controller
    import bpbc_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES,
    parameter bit WAIT_FOR_BUTTON = 1'b0,
    parameter int RAILS = NUM_RAILS,
    parameter int STRAP_W = 3,
    parameter int BOOT_SEL_W = 3,
    // strap pattern per boot select code, entry i at bits [i*STRAP_W +: W]
    parameter logic [(1 << BOOT_SEL_W) * STRAP_W - 1:0] BOOT_MAP =
        24'hFAC688
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // supply, button and rail enables
    input wire logic input_supply_fault_n,
    input wire logic power_button_n,
    output logic [RAILS-1:0] rail_enable,
    output logic carrier_power_enable_n,
    // processor and carrier resets
    output logic cpu_por_n,
    input wire logic cpu_reset_request_n,
    output logic carrier_reset_n,
    // boot select in, processor straps out
    input wire logic [BOOT_SEL_W-1:0] boot_select,
    output logic [STRAP_W-1:0] boot_strap,
    // ethernet phy leds in, module leds out
    input wire logic phy_led1,
    input wire logic phy_led2,
    output logic led_link1000_n,
    output logic led_link100,
    output logic led_activity_n,
    // register bus from the i2c target core
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // camera routing, camera present and backlight
    output logic [1:0] camera_route_config,
    output logic [1:0] camera_present_pins,
    output logic backlight_pwm
);
    localparam int TW = $clog2(TICK_COUNT + 1);
    localparam int RW = $clog2(RAILS + 1);

    // elaboration checks
    if (TICK_COUNT < 1)
        $error("tick count must be at least one");
    if (RAILS < 1 || RAILS > 16)
        $error("rail count out of range");
    if (BOOT_SEL_W < 1 || BOOT_SEL_W > 4)
        $error("boot select width out of range");

    typedef enum logic [2:0] {
        BPBC_WAIT_SUPPLY = 3'h0,
        BPBC_WAIT_BUTTON = 3'h1,
        BPBC_RAMP = 3'h2,
        BPBC_CARRIER_ON = 3'h3,
        BPBC_RUNNING = 3'h4
    } bpbc_state_t;

    bpbc_state_t state; // sequencer state
    logic [TW-1:0] tick_cnt; // 1 ms divider
    logic tick; // one cycle enable per ms
    logic [RW-1:0] rails_on; // rails enabled so far
    logic supply_ok; // synchronised supply fault pin (high = good)
    logic button_n; // synchronised power button
    logic reset_req_n; // synchronised reset request
    logic reset_req_q; // previous value for edge detect
    logic [BOOT_SEL_W-1:0] boot_sel_s; // synchronised boot select
    logic [7:0] board_control; // control register
    logic [7:0] backlight_duty; // pwm duty register
    logic [7:0] pwm_cnt; // free running pwm counter
    logic strap_load; // strap reload event

    // pin synchronisers
    bpbc_sync #(.RESET_VALUE(1'b0)) u_sync_supply (
        .core_clk(core_clk), .rstn(rstn),
        .pin(input_supply_fault_n), .level(supply_ok)
    );
    bpbc_sync #(.RESET_VALUE(1'b1)) u_sync_button (
        .core_clk(core_clk), .rstn(rstn),
        .pin(power_button_n), .level(button_n)
    );
    bpbc_sync #(.RESET_VALUE(1'b1)) u_sync_rreq (
        .core_clk(core_clk), .rstn(rstn),
        .pin(cpu_reset_request_n), .level(reset_req_n)
    );
    for (genvar i = 0; i < BOOT_SEL_W; i++)
    begin : g_bsel
        bpbc_sync #(.RESET_VALUE(1'b0)) u_sync_bsel (
            .core_clk(core_clk), .rstn(rstn),
            .pin(boot_select[i]), .level(boot_sel_s[i])
        );
    end

    // 1 ms tick divider
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else if (tick_cnt == TW'(TICK_COUNT - 1))
        begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // power sequencing state machine, advances only on ticks
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state <= BPBC_WAIT_SUPPLY;
            rails_on <= '0;
        end
        else if (tick)
        begin
            case (state)
                BPBC_WAIT_SUPPLY:
                begin
                    // a fault during ramp is not handled; rails stay on
                    if (supply_ok)
                        state <= WAIT_FOR_BUTTON ? BPBC_WAIT_BUTTON
                                                 : BPBC_RAMP;
                end
                BPBC_WAIT_BUTTON:
                begin
                    if (!button_n)
                        state <= BPBC_RAMP;
                end
                BPBC_RAMP:
                begin
                    // one more rail per tick keeps adjacent rails apart
                    if (rails_on == RW'(RAILS))
                        state <= BPBC_CARRIER_ON;
                    else
                        rails_on <= rails_on + 1'b1;
                end
                BPBC_CARRIER_ON:
                begin
                    state <= BPBC_RUNNING;
                end
                BPBC_RUNNING:
                begin
                    state <= BPBC_RUNNING;
                end
                default:
                begin
                    state <= BPBC_WAIT_SUPPLY;
                end
            endcase
        end
    end

    // rail enables in fixed order, bit 0 first
    for (genvar r = 0; r < RAILS; r++)
    begin : g_rail
        always_ff @(posedge core_clk)
        begin
            if (!rstn)
                rail_enable[r] <= 1'b0;
            else
                rail_enable[r] <= (rails_on > RW'(r));
        end
    end

    // carrier power and cpu reset outputs
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            carrier_power_enable_n <= 1'b1;
            cpu_por_n <= 1'b0;
        end
        else
        begin
            carrier_power_enable_n <= !(state == BPBC_CARRIER_ON ||
                                        state == BPBC_RUNNING);
            cpu_por_n <= (state == BPBC_RUNNING);
        end
    end

    // carrier reset: held until cpu runs, follows request or forced bit
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            carrier_reset_n <= 1'b0;
        else
            carrier_reset_n <= (state == BPBC_RUNNING) && reset_req_n &&
                               !board_control[CTL_CARRIER_RST];
    end

    // strap reload every cycle while cpu_por_n is low, or on a processor reset request edge
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            reset_req_q <= 1'b1;
        else
            reset_req_q <= reset_req_n;
    end
    assign strap_load = (reset_req_q && !reset_req_n) || !cpu_por_n;

    // boot straps; pattern table allows any processor boot mode
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            boot_strap <= '0;
        else if (strap_load)
            boot_strap <= BOOT_MAP[boot_sel_s * STRAP_W +: STRAP_W];
    end

    // led remap: phy led1 low = gigabit link, led2 low = activity
    // a plain gate keeps the led path free of clock latency
    always_comb
    begin
        led_link1000_n = phy_led1;
        led_link100 = phy_led1 & !phy_led2;
        led_activity_n = phy_led2;
    end

    // register writes from the i2c target
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            board_control <= BOARD_CONTROL_RST;
            backlight_duty <= BACKLIGHT_DUTY_RST;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                ADDR_BOARD_CONTROL: board_control <= {3'h0, reg_wdata[4:0]};
                ADDR_BACKLIGHT_DUTY: backlight_duty <= reg_wdata;
                default: ; // status and unmapped writes ignored
            endcase
        end
    end

    // register read data, registered on the read strobe
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                ADDR_BOARD_CONTROL: reg_rdata <= board_control;
                ADDR_BACKLIGHT_DUTY: reg_rdata <= backlight_duty;
                ADDR_SUPPLY_STATUS: reg_rdata <= {7'h00, supply_ok};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // camera routing and present pins straight from control
    always_comb
    begin
        camera_route_config = board_control[CTL_ROUTE_LSB +: 2];
        camera_present_pins = board_control[CTL_CAM_LSB +: 2];
    end

    // backlight pwm, duty 0 gives always low, 255 gives 255/256
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            pwm_cnt <= 8'h00;
            backlight_pwm <= 1'b0;
        end
        else
        begin
            pwm_cnt <= pwm_cnt + 8'h01;
            backlight_pwm <= (pwm_cnt < backlight_duty);
        end
    end
endmodule
`default_nettype wire

// [test/bpbc_props.sv]
// port checker for the board power and boot controller
`timescale 1ns/1ps
`default_nettype none
module bpbc_props
    import bpbc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // supply, rails and resets
    input wire logic input_supply_fault_n,
    input wire logic [5:0] rail_enable,
    input wire logic carrier_power_enable_n,
    input wire logic cpu_por_n,
    input wire logic carrier_reset_n,
    // phy and module leds
    input wire logic phy_led1,
    input wire logic phy_led2,
    input wire logic led_link1000_n,
    input wire logic led_link100,
    input wire logic led_activity_n,
    // register bus and register driven pins
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] camera_route_config,
    input wire logic [1:0] camera_present_pins,
    input wire logic backlight_pwm
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // control write strobe, decoded once for several checks
    wire logic wr_ctl = reg_write && reg_addr == ADDR_BOARD_CONTROL;
    a_led_remap: assert property (
        led_link1000_n == phy_led1 && led_activity_n == phy_led2 &&
        led_link100 == (phy_led1 & ~phy_led2)) else $error("led remap");
    // rails only ever grow by the next bit in line
    a_rail_step: assert property (
        $changed(rail_enable) |-> rail_enable ==
        ($past(rail_enable) << 1 | 6'h01)) else $error("rail order");
    a_rail_spacing: assert property (
        $changed(rail_enable) |=> $stable(rail_enable)[*8])
        else $error("rails too close");
    a_power_after_rails: assert property (
        $fell(carrier_power_enable_n) |-> rail_enable == 6'h3F &&
        $past(rail_enable) == 6'h3F) else $error("carrier power early");
    a_release_after_power: assert property (
        $rose(cpu_por_n) |-> $past(carrier_power_enable_n) == 1'b0)
        else $error("cpu released early");
    // supply must have been good well before the first rail
    a_supply_gate: assert property (
        $rose(rail_enable[0]) |-> $past(input_supply_fault_n, 5))
        else $error("rail without supply");
    a_route_write: assert property (
        wr_ctl |=> {camera_present_pins, camera_route_config} ==
        $past(reg_wdata[3:0])) else $error("route pins");
    a_force_carrier: assert property (
        wr_ctl && reg_wdata[4] |=> ##1 !carrier_reset_n)
        else $error("carrier reset not forced");
    // the pin is synchronised, so only a settled level is compared
    a_status_read: assert property (
        $stable(input_supply_fault_n)[*6] ##0 (reg_read &&
        reg_addr == ADDR_SUPPLY_STATUS) |=> reg_rdata ==
        {7'h00, $past(input_supply_fault_n)}) else $error("status read");
    c_cpu_release: cover property ($rose(cpu_por_n));
    c_carrier_forced: cover property ($fell(carrier_reset_n));
    c_pwm_high: cover property ($rose(backlight_pwm));
endmodule
bind bpbc_board_power_boot_controller bpbc_props i_props (.core_clk,
    .rstn, .input_supply_fault_n, .rail_enable, .carrier_power_enable_n,
    .cpu_por_n, .carrier_reset_n, .phy_led1, .phy_led2, .led_link1000_n,
    .led_link100, .led_activity_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .camera_route_config, .camera_present_pins,
    .backlight_pwm);
`default_nettype wire

// [test/bpbc_host_model.sv]
// host model on the register bus of the i2c target core
`timescale 1ns/1ps
`default_nettype none
module bpbc_host_model (
    // clock
    input wire logic core_clk,
    // register request out, read data in
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    // idle bus; the reprogramming target is never touched
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // one strobe edge, then the bus shows the inverse, not stale data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // read data is taken one and a half cycles after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        @(negedge core_clk);
        q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [test/bpbc_board_power_boot_controller_tb.sv]
// self-checking bench of the board power and boot controller
`timescale 1ns/1ps
`default_nettype none
module bpbc_board_power_boot_controller_tb;
    import bpbc_pkg::*;
    // strap table for the design, arbitrary pattern
    localparam logic [23:0] MAP = 24'hFAC688;
    // bench driven pins
    logic core_clk, rstn, sup_n, btn_n, req_n, led1, led2;
    logic [2:0] bsel;
    // design outputs and register bus
    logic [5:0] rails;
    logic cpe_n, por_n, crst_n, l1k_n, l100, lact_n, wr, rd, pwm;
    logic [2:0] strap;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] route, cam;
    int err_total, n_compared;
    bpbc_board_power_boot_controller #(.TICK_COUNT(10),
        .WAIT_FOR_BUTTON(1'b1), .BOOT_MAP(MAP)) i_dut (
        .core_clk, .rstn, .input_supply_fault_n(sup_n),
        .power_button_n(btn_n), .rail_enable(rails),
        .carrier_power_enable_n(cpe_n), .cpu_por_n(por_n),
        .cpu_reset_request_n(req_n), .carrier_reset_n(crst_n),
        .boot_select(bsel), .boot_strap(strap), .phy_led1(led1),
        .phy_led2(led2), .led_link1000_n(l1k_n), .led_link100(l100),
        .led_activity_n(lact_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr), .reg_read(rd), .reg_rdata(rdata),
        .camera_route_config(route), .camera_present_pins(cam),
        .backlight_pwm(pwm));
    bpbc_host_model i_host (.core_clk, .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr), .reg_read(rd), .reg_rdata(rdata));
    // verdict and end of run
    task automatic conclude;
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // case equality so an unknown never passes
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // supply gate, button hold, then ramp until the cpu is released
    task automatic t_startup;
        logic [5:0] prev;
        int n;
        cyc(100);
        chk("rails", {2'h0, rails}, 8'h00);
        chk("reset strap", {5'h00, strap}, {5'h00, MAP[15 +: 3]});
        sup_n = 1'b1;
        cyc(100);
        chk("rails", {2'h0, rails}, 8'h00);
        btn_n = 1'b0;
        prev = rails;
        for (n = 0; n < 400 && por_n !== 1'b1; n++)
        begin
            cyc(1);
            if (rails !== prev)
                chk("rail step", {2'h0, rails}, {1'b0, prev, 1'b1});
            prev = rails;
        end
        // a sequencer that never releases the cpu ends the run here
        if (n == 400)
        begin
            err_total++;
            conclude();
        end
        else
        begin
            chk("power", {6'h00, cpe_n, crst_n}, 8'h01);
            chk("rails", {2'h0, rails}, 8'h3F);
        end
    endtask
    // every boot select code, latched at a cpu reset request
    task automatic t_boot;
        for (int i = 0; i < 8; i++)
        begin
            bsel = i[2:0];
            cyc(8);
            req_n = 1'b0;
            cyc(8);
            chk("strap", {5'h00, strap}, {5'h00, MAP[i*3 +: 3]});
            chk("carrier reset", {7'h00, crst_n}, 8'h00);
            req_n = 1'b1;
            cyc(8);
            chk("carrier reset", {7'h00, crst_n}, 8'h01);
        end
    endtask
    // all phy led combinations
    task automatic t_leds;
        for (int i = 0; i < 4; i++)
        begin
            {led1, led2} = i[1:0];
            cyc(1);
            chk("leds", {5'h00, l1k_n, l100, lact_n},
                {5'h00, i[1], i[1] & ~i[0], i[0]});
        end
    endtask
    // reset values, unmapped and read-only places, routing, forced reset
    task automatic t_regs;
        logic [7:0] q;
        i_host.rd(ADDR_BOARD_CONTROL, q);
        chk("control", q, BOARD_CONTROL_RST);
        i_host.rd(ADDR_BACKLIGHT_DUTY, q);
        chk("duty", q, BACKLIGHT_DUTY_RST);
        i_host.rd(8'h03, q);
        chk("unmapped", q, 8'h00);
        i_host.wr(ADDR_SUPPLY_STATUS, 8'h00);
        i_host.rd(ADDR_SUPPLY_STATUS, q);
        chk("status", q, 8'h01);
        sup_n = 1'b0;
        cyc(8);
        i_host.rd(ADDR_SUPPLY_STATUS, q);
        chk("status", q, 8'h00);
        sup_n = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            i_host.wr(ADDR_BOARD_CONTROL, {3'h7, 1'b0, ~i[1:0], i[1:0]});
            chk("route", {4'h0, cam, route},
                {4'h0, ~i[1:0], i[1:0]});
            i_host.rd(ADDR_BOARD_CONTROL, q);
            chk("control", q, {4'h0, ~i[1:0], i[1:0]});
        end
        i_host.wr(ADDR_BOARD_CONTROL, 8'h10);
        cyc(1);
        chk("carrier reset", {7'h00, crst_n}, 8'h00);
    endtask
    // high cycles over one full pwm period equal the duty value
    task automatic t_pwm;
        logic [7:0] d;
        int hi;
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'h40 : 8'hFF;
            i_host.wr(ADDR_BACKLIGHT_DUTY, d);
            cyc(4);
            hi = 0;
            repeat (256)
            begin
                cyc(1);
                if (pwm === 1'b1)
                    hi++;
            end
            chk("pwm high", hi[7:0], d);
        end
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        {err_total, n_compared} = 0;
        {rstn, sup_n, led1, led2} = 4'h0;
        {btn_n, req_n} = 2'h3;
        bsel = 3'h5;
        cyc(20);
        rstn = 1'b1;
        t_startup();
        t_boot();
        t_leds();
        t_regs();
        t_pwm();
        conclude();
    end
endmodule
`default_nettype wire
